/* verilog/dpmc_pkg.sv */
// Package with register map, field layout and constants of the mode control
package dpmc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0]  DPMC_MODE_TWO_ADDR   = 8'h2c;
    localparam logic [7:0]  DPMC_STATUS_ADDR     = 8'h30;
    localparam logic [15:0] DPMC_MODE_TWO_RESET  = 16'h0000;
    localparam logic [15:0] DPMC_MODE_TWO_WMASK  = 16'h0fff;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int DPMC_FDS_LSB   = 8;
    localparam int DPMC_B_CLOCK_FAIL_OUT_ENABLE_BIT  = 7;
    localparam int DPMC_A_CLOCK_FAIL_OUT_ENABLE_BIT  = 6;
    localparam int DPMC_INV_BIT   = 5;
    localparam int DPMC_DIV_LSB   = 3;
    localparam int DPMC_SRC_LSB   = 0;

    // ****************************************************************
    // Divider ratios
    // ****************************************************************
    localparam int DPMC_DIV_A     = 193;
    localparam int DPMC_DIV_B     = 256;

    // AXI responses
    localparam logic [1:0] DPMC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] DPMC_RESP_SLVERR = 2'b10;

    // Failure detection selection
    typedef enum logic [1:0] {
        DPMC_FD_AUTO      = 2'b00,
        DPMC_FD_EXTERNAL  = 2'b01,
        DPMC_FD_FORCE_PRI = 2'b10,
        DPMC_FD_FORCE_SEC = 2'b11
    } dpmc_fd_t;

    // Divider codes
    typedef enum logic [1:0] {
        DPMC_DIV_PASS = 2'b00,
        DPMC_DIV_193  = 2'b01,
        DPMC_DIV_256  = 2'b10,
        DPMC_DIV_RSVD = 2'b11
    } dpmc_div_t;

endpackage : dpmc_pkg

/* verilog/dpmc_ref_divider.sv */
// Divides the chosen local reference by 193 or 256 for the recovered output
`timescale 1ns/10ps
module dpmc_ref_divider
    import dpmc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic [1:0] div_sel_i,
    input  wire logic       ref_i,
    // Result
    output logic            ref_o
);

    logic       ref_q;
    logic [8:0] cnt;
    logic [8:0] next_cnt;
    logic       next_ref_q;
    logic       out_q;
    logic       next_out_q;
    logic [8:0] ratio;

    // Divide on rising edges of the sampled reference
    always_comb begin
        next_ref_q = ref_i;
        next_cnt   = cnt;
        next_out_q = out_q;
        ratio      = (div_sel_i == DPMC_DIV_193) ? 9'(DPMC_DIV_A)
                                                 : 9'(DPMC_DIV_B);
        case (div_sel_i)
            DPMC_DIV_PASS: begin
                next_cnt   = 9'h000;
                next_out_q = ref_i;
            end
            DPMC_DIV_193, DPMC_DIV_256: begin
                if (ref_i && !ref_q) begin
                    if (cnt >= ratio - 9'h001) begin
                        next_cnt = 9'h000;
                    end else begin
                        next_cnt = cnt + 9'h001;
                    end
                    // High for the first half of each output period
                    next_out_q = (next_cnt < (ratio >> 1));
                end
            end
            default: begin
                // Reserved code: output held low
                next_cnt   = 9'h000;
                next_out_q = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_q <= 1'b0;
            cnt   <= 9'h000;
            out_q <= 1'b0;
        end else begin
            ref_q <= next_ref_q;
            cnt   <= next_cnt;
            out_q <= next_out_q;
        end
    end

    assign ref_o = out_q;

endmodule : dpmc_ref_divider

/* verilog/dpmc_mode_ctrl.sv */
// Mode control register two of the loop: reference choice, fail outputs
//
// Functional notes
// - Code 00 selects using internal monitor failures
// - Code 01 uses external loss-of-signal inputs
// - Code 10 forces the primary reference
// - Code 11 forces the secondary reference
// - Bit 7 drives or tri-states B fail
// - Bit 6 drives or tri-states A fail
// - Bit 5 inverts both backplane references
// - Bits 4-3 pass, divide 193 or 256
// - Bits 2-0 pick one of eight locals
`timescale 1ns/10ps
module dpmc_mode_ctrl
    import dpmc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] awaddr_i,
    input  wire logic              awvalid_i,
    output logic                   awready_o,
    input  wire logic [31:0]       wdata_i,
    input  wire logic [3:0]        wstrb_i,
    input  wire logic              wvalid_i,
    output logic                   wready_o,
    output logic [1:0]             bresp_o,
    output logic                   bvalid_o,
    input  wire logic              bready_i,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr_i,
    input  wire logic              arvalid_i,
    output logic                   arready_o,
    output logic [31:0]            rdata_o,
    output logic [1:0]             rresp_o,
    output logic                   rvalid_o,
    input  wire logic              rready_i,
    // Reference inputs
    input  wire logic              backplane_reference_one_i,
    input  wire logic              backplane_reference_two_i,
    input  wire logic [7:0]        local_reference_i,
    // Failure sources
    input  wire logic              pri_internal_fail_i,
    input  wire logic              sec_internal_fail_i,
    input  wire logic              primary_loss_of_signal_in_i,
    input  wire logic              secondary_loss_of_signal_in_i,
    input  wire logic              a_clock_fail_i,
    input  wire logic              b_clock_fail_i,
    // Loop side
    output logic                   loop_ref_one_o,
    output logic                   loop_ref_two_o,
    output logic                   use_secondary_o,
    output logic                   pri_fail_o,
    output logic                   sec_fail_o,
    // Fail pins
    output logic                   a_clock_fail_o,
    output logic                   a_clock_fail_oe_o,
    output logic                   b_clock_fail_o,
    output logic                   b_clock_fail_oe_o,
    // Recovered reference
    output logic                   recovered_reference_out_o
);

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    // ****************************************************************
    // Register bus slave
    // ****************************************************************
    logic        aw_held, w_held, next_aw_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [15:0] mode_two, next_mode_two;
    logic [15:0] wr_merge;
    logic        sel_src;
    logic        awready, wready, arready;

    // Address and data taken in either order; response once both held
    always_comb begin
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_mode_two = mode_two;
        wr_merge      = mode_two;
        if (awvalid_i && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr_i;
        end
        if (wvalid_i && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = wdata_i;
            next_w_strb = wstrb_i;
        end
        if (bvalid && bready_i) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (aw_addr[7:2] == DPMC_MODE_TWO_ADDR[7:2]) begin
                if (w_strb[0]) wr_merge[7:0]  = w_data[7:0];
                if (w_strb[1]) wr_merge[15:8] = w_data[15:8];
                // Top nibble reserved, stays zero
                next_mode_two = wr_merge & DPMC_MODE_TWO_WMASK;
                next_bresp    = DPMC_RESP_OKAY;
            end else if (aw_addr[7:2] == DPMC_STATUS_ADDR[7:2]) begin
                next_bresp = DPMC_RESP_OKAY;    // Read-only, write ignored
            end else begin
                next_bresp = DPMC_RESP_SLVERR;
            end
        end
    end

    // Read answer one cycle after the address is taken
    always_comb begin
        next_rvalid = rvalid;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (rvalid && rready_i) begin
            next_rvalid = 1'b0;
        end
        if (arvalid_i && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = DPMC_RESP_OKAY;
            if (araddr_i[7:2] == DPMC_MODE_TWO_ADDR[7:2]) begin
                next_rdata = {16'h0000, mode_two};
            end else if (araddr_i[7:2] == DPMC_STATUS_ADDR[7:2]) begin
                next_rdata = {27'h0000000, recovered_reference_out_o,
                              pri_fail_o, sec_fail_o, use_secondary_o,
                              sel_src};
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = DPMC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= '0;
            w_data   <= 32'h00000000;
            w_strb   <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= DPMC_RESP_OKAY;
            rvalid   <= 1'b0;
            rresp    <= DPMC_RESP_OKAY;
            rdata    <= 32'h00000000;
            mode_two <= DPMC_MODE_TWO_RESET;
            awready  <= 1'b1;
            wready   <= 1'b1;
            arready  <= 1'b1;
        end else begin
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rresp    <= next_rresp;
            rdata    <= next_rdata;
            mode_two <= next_mode_two;
            awready  <= !next_aw_held;
            wready   <= !next_w_held;
            arready  <= !next_rvalid;
        end
    end

    assign awready_o = awready;
    assign wready_o  = wready;
    assign bvalid_o  = bvalid;
    assign bresp_o   = bresp;
    assign arready_o = arready;
    assign rvalid_o  = rvalid;
    assign rresp_o   = rresp;
    assign rdata_o   = rdata;

    // ****************************************************************
    // Field decode
    // ****************************************************************
    dpmc_fd_t   failure_detect_select;
    logic       b_clock_fail_out_enable;
    logic       a_clock_fail_out_enable;
    logic       backplane_ref_invert;
    logic [1:0] recovered_ref_divider;
    logic [2:0] recovered_ref_source_select;

    assign failure_detect_select =
        dpmc_fd_t'(mode_two[DPMC_FDS_LSB +: 2]);
    assign b_clock_fail_out_enable = mode_two[DPMC_B_CLOCK_FAIL_OUT_ENABLE_BIT];
    assign a_clock_fail_out_enable = mode_two[DPMC_A_CLOCK_FAIL_OUT_ENABLE_BIT];
    assign backplane_ref_invert    = mode_two[DPMC_INV_BIT];
    assign recovered_ref_divider   = mode_two[DPMC_DIV_LSB +: 2];
    assign recovered_ref_source_select = mode_two[DPMC_SRC_LSB +: 3];

    // ****************************************************************
    // Reference choice and pins
    // ****************************************************************
    logic pri_f, sec_f, use_sec, next_use_sec, next_pri_f, next_sec_f;
    logic loop1, loop2, afo, afoe, bfo, bfoe, srcq;

    // Failure source per mode; forced modes ignore monitors in the choice, fail flags still follow internal monitors
    always_comb begin
        next_pri_f   = pri_internal_fail_i;
        next_sec_f   = sec_internal_fail_i;
        next_use_sec = use_sec;
        case (failure_detect_select)
            DPMC_FD_AUTO: begin
                next_pri_f = pri_internal_fail_i;
                next_sec_f = sec_internal_fail_i;
                if (next_pri_f && !next_sec_f) next_use_sec = 1'b1;
                if (!next_pri_f) next_use_sec = 1'b0;
            end
            DPMC_FD_EXTERNAL: begin
                next_pri_f = primary_loss_of_signal_in_i;
                next_sec_f = secondary_loss_of_signal_in_i;
                if (next_pri_f && !next_sec_f) next_use_sec = 1'b1;
                if (!next_pri_f) next_use_sec = 1'b0;
            end
            DPMC_FD_FORCE_PRI: begin
                next_use_sec = 1'b0;
            end
            default: begin
                next_use_sec = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pri_f   <= 1'b0;
            sec_f   <= 1'b0;
            use_sec <= 1'b0;
            loop1   <= 1'b0;
            loop2   <= 1'b0;
            afo     <= 1'b0;
            afoe    <= 1'b0;
            bfo     <= 1'b0;
            bfoe    <= 1'b0;
            srcq    <= 1'b0;
        end else begin
            pri_f   <= next_pri_f;
            sec_f   <= next_sec_f;
            use_sec <= next_use_sec;
            loop1   <= backplane_reference_one_i ^ backplane_ref_invert;
            loop2   <= backplane_reference_two_i ^ backplane_ref_invert;
            afo     <= a_clock_fail_i;
            afoe    <= a_clock_fail_out_enable;
            bfo     <= b_clock_fail_i;
            bfoe    <= b_clock_fail_out_enable;
            srcq    <= local_reference_i[recovered_ref_source_select];
        end
    end

    assign sel_src           = srcq;
    assign pri_fail_o        = pri_f;
    assign sec_fail_o        = sec_f;
    assign use_secondary_o   = use_sec;
    assign loop_ref_one_o    = loop1;
    assign loop_ref_two_o    = loop2;
    assign a_clock_fail_o    = afo;
    assign a_clock_fail_oe_o = afoe;
    assign b_clock_fail_o    = bfo;
    assign b_clock_fail_oe_o = bfoe;

    // Divider on the selected local reference
    dpmc_ref_divider u_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .div_sel_i (recovered_ref_divider),
        .ref_i     (srcq),
        .ref_o     (recovered_reference_out_o)
    );

endmodule : dpmc_mode_ctrl

/* verif/dpmc_mode_ctrl_monitor.sv */
// Checker of the mode control outputs against a shadow of the register
`timescale 1ns/10ps
module dpmc_mode_ctrl_monitor
    import dpmc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // Register writes
    input wire logic [ADDR_W-1:0] awaddr_i,
    input wire logic              awvalid_i,
    input wire logic              awready_o,
    input wire logic [31:0]       wdata_i,
    input wire logic [3:0]        wstrb_i,
    input wire logic              wvalid_i,
    input wire logic              wready_o,
    // Sources
    input wire logic              backplane_reference_one_i,
    input wire logic [7:0]        local_reference_i,
    input wire logic              pri_internal_fail_i,
    input wire logic              primary_loss_of_signal_in_i,
    // Watched outputs
    input wire logic              loop_ref_one_o,
    input wire logic              use_secondary_o,
    input wire logic              pri_fail_o,
    input wire logic              a_clock_fail_oe_o,
    input wire logic              b_clock_fail_oe_o,
    input wire logic              recovered_reference_out_o
);
    logic [15:0] shadow;
    logic [15:0] next_shadow;
    logic [2:0]  settle;
    logic [2:0]  next_settle;
    logic        quiet;
    logic        sel_ref;

    // Shadow copy; writes taken apart from their address are not seen
    always_comb begin
        next_shadow = shadow;
        next_settle = (settle == 3'h7) ? settle : settle + 3'h1;
        if (awvalid_i && awready_o && wvalid_i && wready_o &&
            awaddr_i == ADDR_W'(DPMC_MODE_TWO_ADDR)) begin
            if (wstrb_i[0]) next_shadow[7:0] = wdata_i[7:0];
            if (wstrb_i[1]) next_shadow[11:8] = wdata_i[11:8];
            next_settle = 3'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        shadow <= rst_i ? 16'h0000 : next_shadow;
        settle <= rst_i ? 3'h0 : next_settle;
    end
    // Hold checks off until a write has had time to reach the outputs
    assign quiet = settle >= 3'h5;
    assign sel_ref = local_reference_i[shadow[2:0]];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_auto;
        quiet && shadow[9:8] == 2'b00 |->
            pri_fail_o == $past(pri_internal_fail_i);
    endproperty
    a_auto: assert property (p_auto) else $error("monitor fail unused");
    property p_ext;
        quiet && shadow[9:8] == 2'b01 |->
            pri_fail_o == $past(primary_loss_of_signal_in_i);
    endproperty
    a_ext: assert property (p_ext) else $error("los input unused");
    property p_fpri;
        quiet && shadow[9:8] == 2'b10 |-> !use_secondary_o;
    endproperty
    a_fpri: assert property (p_fpri) else $error("primary not forced");
    property p_fsec;
        quiet && shadow[9:8] == 2'b11 |-> use_secondary_o;
    endproperty
    a_fsec: assert property (p_fsec) else $error("secondary not forced");
    property p_boe;
        quiet |-> b_clock_fail_oe_o == shadow[7] && $stable(b_clock_fail_oe_o);
    endproperty
    a_boe: assert property (p_boe) else $error("b enable wrong");
    property p_aoe;
        quiet |-> a_clock_fail_oe_o == shadow[6];
    endproperty
    a_aoe: assert property (p_aoe) else $error("a enable wrong");
    property p_inv;
        quiet |->
            loop_ref_one_o == ($past(backplane_reference_one_i) ^ shadow[5]);
    endproperty
    a_inv: assert property (p_inv) else $error("inversion wrong");
    property p_pass;
        quiet && shadow[4:3] == 2'b00 |->
            recovered_reference_out_o == $past(sel_ref, 2);
    endproperty
    a_pass: assert property (p_pass) else $error("pass source wrong");
    property p_rsvd;
        quiet && shadow[4:3] == 2'b11 |-> !recovered_reference_out_o;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved not low");
endmodule : dpmc_mode_ctrl_monitor

bind dpmc_mode_ctrl dpmc_mode_ctrl_monitor #(.ADDR_W(ADDR_W)) dpmc_mon_i (
    .clk_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
    .wvalid_i, .wready_o, .backplane_reference_one_i, .local_reference_i,
    .pri_internal_fail_i, .primary_loss_of_signal_in_i, .loop_ref_one_o,
    .use_secondary_o, .pri_fail_o, .a_clock_fail_oe_o, .b_clock_fail_oe_o,
    .recovered_reference_out_o
);

/* verif/dpmc_ref_model.sv */
// Model of the backplane and local reference clocks
`timescale 1ns/10ps
module dpmc_ref_model (
    // Clock
    input  wire logic  clk_i,
    // References
    output logic       backplane_reference_one_o,
    output logic       backplane_reference_two_o,
    output logic [7:0] local_reference_o
);
    logic [3:0] cnt [8];
    logic [7:0] lfsr;

    initial begin
        lfsr = 8'h5a;
        local_reference_o = 8'h00;
        for (int k = 0; k < 8; k++) cnt[k] = 4'h0;
    end
    // Local reference k toggles every k+2 clocks; backplane ones wander
    always @(posedge clk_i) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        for (int k = 0; k < 8; k++) begin
            if (cnt[k] == 4'(k + 1)) begin
                cnt[k] <= 4'h0;
                local_reference_o[k] <= ~local_reference_o[k];
            end else begin
                cnt[k] <= cnt[k] + 4'h1;
            end
        end
    end
    assign backplane_reference_one_o = lfsr[0];
    assign backplane_reference_two_o = lfsr[7];
endmodule : dpmc_ref_model

/* verif/tb_dpmc_mode_ctrl.sv */
// Self-checking bench of the mode register and its outputs
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_dpmc_mode_ctrl
    import dpmc_pkg::*;
;
    logic        clk_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
    logic        rready_i, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic [7:0]  awaddr_i, araddr_i, local_reference_i;
    logic [31:0] wdata_i, rdata_o;
    logic [3:0]  wstrb_i;
    logic [1:0]  bresp_o, rresp_o;
    logic        backplane_reference_one_i, backplane_reference_two_i;
    logic        pri_internal_fail_i, sec_internal_fail_i;
    logic        primary_loss_of_signal_in_i, secondary_loss_of_signal_in_i;
    logic        a_clock_fail_i, b_clock_fail_i, loop_ref_one_o, loop_ref_two_o;
    logic        use_secondary_o, pri_fail_o, sec_fail_o, a_clock_fail_o;
    logic        a_clock_fail_oe_o, b_clock_fail_o, b_clock_fail_oe_o;
    logic        recovered_reference_out_o, bp1_d, bp2_d;
    int          fails, checks_done, cyc;

    dpmc_mode_ctrl dpmc_mode_ctrl_i (
        .clk_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
        .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
        .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
        .backplane_reference_one_i, .backplane_reference_two_i,
        .local_reference_i, .pri_internal_fail_i, .sec_internal_fail_i,
        .primary_loss_of_signal_in_i, .secondary_loss_of_signal_in_i,
        .a_clock_fail_i, .b_clock_fail_i, .loop_ref_one_o, .loop_ref_two_o,
        .use_secondary_o, .pri_fail_o, .sec_fail_o, .a_clock_fail_o,
        .a_clock_fail_oe_o, .b_clock_fail_o, .b_clock_fail_oe_o,
        .recovered_reference_out_o
    );
    dpmc_ref_model dpmc_ref_model_i (
        .clk_i(clk_i),
        .backplane_reference_one_o(backplane_reference_one_i),
        .backplane_reference_two_o(backplane_reference_two_i),
        .local_reference_o(local_reference_i)
    );

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Sampled references; hang ceiling
    always @(posedge clk_i) begin
        bp1_d <= backplane_reference_one_i;
        bp2_d <= backplane_reference_two_i;
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge clk_i);
        awaddr_i <= a;
        wdata_i <= d;
        wstrb_i <= s;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready_o === 1'b1) awvalid_i <= 1'b0;
            if (wready_o === 1'b1) wvalid_i <= 1'b0;
        end while (bvalid_o !== 1'b1);
        r = bresp_o;
        bready_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready_o === 1'b1) arvalid_i <= 1'b0;
        end while (rvalid_o !== 1'b1);
        d = rdata_o;
        r = rresp_o;
        rready_i <= 1'b0;
    endtask : rd

    // Write the mode word, then let the registered outputs follow
    task automatic setm(input logic [15:0] v);
        logic [1:0] r;
        wr(DPMC_MODE_TWO_ADDR, {16'h0000, v}, 4'hf, r);
        repeat (6) @(posedge clk_i);
    endtask : setm

    // Clocks from one rise of the recovered output to the next
    task automatic per_of(output int per, output int hi);
        logic p;
        per = 0;
        hi = 0;
        do begin
            p = recovered_reference_out_o;
            @(negedge clk_i);
            per++;
            if (recovered_reference_out_o === 1'b1) hi++;
        end while (!(recovered_reference_out_o === 1'b1 && p === 1'b0)
                   && per < 4000);
    endtask : per_of

    // Period or high time; local reference k has period 2*(k+2)
    function automatic int exp_t(input int k, input logic [1:0] dv,
                                 input bit hi);
        int p;
        int n;
        p = 2 * (k + 2);
        n = (dv == DPMC_DIV_193) ? DPMC_DIV_A : DPMC_DIV_B;
        if (dv == DPMC_DIV_PASS) return hi ? p / 2 : p;
        return hi ? (n / 2) * p : n * p;
    endfunction : exp_t

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] v;
        logic [1:0]  dv;
        int          per;
        int          hi;
        int          k;
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
        {awaddr_i, araddr_i, wdata_i, wstrb_i} = '0;
        {pri_internal_fail_i, sec_internal_fail_i, a_clock_fail_i} = '0;
        {primary_loss_of_signal_in_i, secondary_loss_of_signal_in_i} = '0;
        b_clock_fail_i = 1'b0;
        void'($urandom(32'h97e24d08));
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(DPMC_MODE_TWO_ADDR, d, r);
        `CHK(d, {16'h0000, DPMC_MODE_TWO_RESET})
        // Upper bits read zero, byte enables, status and unmapped places
        wr(DPMC_MODE_TWO_ADDR, 32'hffffffff, 4'hf, r);
        rd(DPMC_MODE_TWO_ADDR, d, r);
        `CHK(d, 32'h00000fff)
        wr(DPMC_MODE_TWO_ADDR, 32'h00000000, 4'h2, r);
        wr(DPMC_STATUS_ADDR, 32'h0000ffff, 4'hf, r);
        `CHK(r, DPMC_RESP_OKAY)
        rd(DPMC_MODE_TWO_ADDR, d, r);
        `CHK(d, 32'h000000ff)
        hi = 0;
        repeat (40) @(negedge clk_i) hi += (recovered_reference_out_o !== 1'b0);
        `CHK(hi, 0)
        rd(8'h40, d, r);
        `CHK({d, r}, {32'h0, DPMC_RESP_SLVERR})
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom());
            v[9:8] = 2'(i);
            if (v[4:3] == 2'b11) v[4:3] = 2'b00;
            a_clock_fail_i <= 1'($urandom());
            b_clock_fail_i <= 1'($urandom());
            sec_internal_fail_i <= 1'($urandom());
            secondary_loss_of_signal_in_i <= 1'($urandom());
            setm(v);
            rd(DPMC_MODE_TWO_ADDR, d, r);
            `CHK(d, {16'h0000, v & DPMC_MODE_TWO_WMASK})
            `CHK({a_clock_fail_oe_o, b_clock_fail_oe_o}, {v[6], v[7]})
            if (v[6]) `CHK(a_clock_fail_o, a_clock_fail_i)
            if (v[7]) `CHK(b_clock_fail_o, b_clock_fail_i)
            `CHK(use_secondary_o, v[9] & v[8])
            if (v[9:8] == 0) `CHK(sec_fail_o, sec_internal_fail_i)
            repeat (8) begin
                @(negedge clk_i);
                `CHK({loop_ref_one_o, loop_ref_two_o},
                     {bp1_d, bp2_d} ^ {2{v[5]}})
            end
        end
        $display("test random modes done");
        // Only the failure source of the chosen mode moves the loop
        {sec_internal_fail_i, secondary_loss_of_signal_in_i} <= 2'b00;
        for (int m = 0; m < 2; m++) begin
            setm(16'(m) << DPMC_FDS_LSB);
            for (int w = 0; w < 2; w++) begin
                pri_internal_fail_i <= (w == 0);
                primary_loss_of_signal_in_i <= (w == 1);
                repeat (4) @(posedge clk_i);
                `CHK({use_secondary_o, pri_fail_o}, {2{w == m}})
            end
        end
        $display("test failure sources done");
        for (int t = 0; t < 10; t++) begin
            dv = (t < 8) ? 2'b00 : 2'(t - 7);
            k = (t < 8) ? t : $urandom_range(1);
            v = 16'h0000;
            v[4:3] = dv;
            v[2:0] = 3'(k);
            setm(v);
            per_of(per, hi);
            per_of(per, hi);
            per_of(per, hi);
            `CHK(per, exp_t(k, dv, 1'b0))
            `CHK(hi, exp_t(k, dv, 1'b1))
        end
        $display("test recovered output done");
        end_of_test();
    end
endmodule : tb_dpmc_mode_ctrl
